// file: shared/dis_defines.svh
// Register offsets, field layouts and reset values of the split configuration bank
`ifndef DIS_DEFINES_SVH
`define DIS_DEFINES_SVH

`define DIS_ADDR_W              8
`define DIS_OFF_LINE_LOW        8'h32
`define DIS_OFF_LINE_HIGH       8'h33
`define DIS_OFF_LAG_LOW         8'h34
`define DIS_OFF_LAG_HIGH        8'h35
`define DIS_OFF_PORT_SEL        8'h3f
`define DIS_HIGH_FIELD_W        5
`define DIS_LINE_LOW_RESET      8'h00
`define DIS_LINE_HIGH_RESET     5'h05
`define DIS_LAG_LOW_RESET       8'h0c
`define DIS_RDATA_IDLE          8'h00
`define DIS_LAG_HIGH_RESET      5'h00
`define DIS_MAX_PIXELS          13'h1000

`endif

// file: shared/dis_pkg.sv
// Types shared by the split configuration bank
package dis_pkg;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dis_req_s;

    // Per-port delay value
    typedef logic [12:0] dis_pix_t;

    // Output link ports
    typedef enum logic {
        DIS_PORT0,
        DIS_PORT1
    } dis_port_e;

endpackage

// file: verilog/dis_split_config.sv
// Line width and per-port buffering lag registers of the video splitter
//
// Notes on behaviour
// - Line width is 13 bits over two registers.
// - Line width resets to 1280 pixels.
// - Split 3D: width is half combined line.
// - Dual-input mode uses same width value.
// - Incoming pixels buffered for programmed lag.
// - Lag writes go to selected port only.
// - Lag resets to 12 pixels.
// - Lag upper five bits in next register.
`timescale 1ns/10ps
`include "dis_defines.svh"

module dis_split_config
    import dis_pkg::*;
#(
    // Largest line width or lag the splitter supports
    parameter dis_pix_t LIMIT_PIXELS = `DIS_MAX_PIXELS
)
(
    // Clock and reset
    input  wire logic          i_core_clk,
    input  wire logic          i_rst,
    // Register port
    input  wire dis_req_s      i_req,
    output logic [7:0]         o_rdata,
    // Splitter configuration
    output dis_pix_t           o_line_width,
    output logic [13:0]        o_combined_width,
    output dis_pix_t           o_lag_port0,
    output dis_pix_t           o_lag_port1,
    output logic               o_port_sel,
    output logic               o_line_over_limit,
    output logic               o_lag_over_limit
);

    // Register state
    logic [7:0]  split_line_width_low;
    logic [4:0]  split_line_width_high;
    logic [7:0]  split_buffer_lag_low;
    logic [7:0]  split_buffer_lag_low_port1;
    logic [4:0]  split_buffer_lag_high;
    logic [4:0]  split_buffer_lag_high_port1;
    dis_port_e   port_sel;
    logic [7:0]  rdata;

    logic [7:0]  next_line_low;
    logic [4:0]  next_line_high;
    logic [7:0]  next_lag_low0;
    logic [7:0]  next_lag_low1;
    logic [4:0]  next_lag_high0;
    logic [4:0]  next_lag_high1;
    dis_port_e   next_port_sel;
    logic [7:0]  next_rdata;

    // One-hot write decodes
    logic        wr_line_low;
    logic        wr_line_high;
    logic        wr_lag_low;
    logic        wr_lag_high;
    logic        wr_port_sel;
    // Lag bytes of the port software currently sees
    logic [7:0]  seen_lag_low;
    logic [4:0]  seen_lag_high;

    function automatic logic hit(input dis_req_s r, input logic [7:0] off);
        hit = r.wr && (r.addr == off);
    endfunction

    function automatic dis_pix_t join_pix(input logic [4:0] hi, input logic [7:0] lo);
        join_pix = {hi, lo};
    endfunction

    // Upper-byte registers keep only their low field
    function automatic logic [4:0] high_field(input logic [7:0] b);
        high_field = b[`DIS_HIGH_FIELD_W-1:0];
    endfunction

    assign wr_line_low  = hit(i_req, `DIS_OFF_LINE_LOW);
    assign wr_line_high = hit(i_req, `DIS_OFF_LINE_HIGH);
    assign wr_lag_low   = hit(i_req, `DIS_OFF_LAG_LOW);
    assign wr_lag_high  = hit(i_req, `DIS_OFF_LAG_HIGH);
    assign wr_port_sel  = hit(i_req, `DIS_OFF_PORT_SEL);

    // reads follow the selected port too
    assign seen_lag_low  = (port_sel == DIS_PORT1) ? split_buffer_lag_low_port1
                                                   : split_buffer_lag_low;
    assign seen_lag_high = (port_sel == DIS_PORT1) ? split_buffer_lag_high_port1
                                                   : split_buffer_lag_high;

    // line width split over two bytes
    always_comb
    begin
        next_line_low  = split_line_width_low;
        next_line_high = split_line_width_high;
        if (wr_line_low)
            next_line_low = i_req.wdata;
        if (wr_line_high)
            next_line_high = high_field(i_req.wdata);
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            split_line_width_low  <= `DIS_LINE_LOW_RESET;
            split_line_width_high <= `DIS_LINE_HIGH_RESET;
        end
        else
        begin
            split_line_width_low  <= next_line_low;
            split_line_width_high <= next_line_high;
        end
    end

    // Port select only steers register access, not video
    always_comb
    begin
        next_port_sel = port_sel;
        if (wr_port_sel)
            next_port_sel = dis_port_e'(i_req.wdata[0]);
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            port_sel <= DIS_PORT0;
        else
            port_sel <= next_port_sel;
    end

    // lag writes steered by port select
    always_comb
    begin
        next_lag_low0  = split_buffer_lag_low;
        next_lag_low1  = split_buffer_lag_low_port1;
        next_lag_high0 = split_buffer_lag_high;
        next_lag_high1 = split_buffer_lag_high_port1;
        if (wr_lag_low)
        begin
            if (port_sel == DIS_PORT1)
                next_lag_low1 = i_req.wdata;
            else
                next_lag_low0 = i_req.wdata;
        end
        // lag upper bits in next register
        if (wr_lag_high)
        begin
            if (port_sel == DIS_PORT1)
                next_lag_high1 = high_field(i_req.wdata);
            else
                next_lag_high0 = high_field(i_req.wdata);
        end
    end

    // Bytes land separately, so a half-written lag is briefly visible
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            split_buffer_lag_low        <= `DIS_LAG_LOW_RESET;
            split_buffer_lag_low_port1  <= `DIS_LAG_LOW_RESET;
            split_buffer_lag_high       <= `DIS_LAG_HIGH_RESET;
            split_buffer_lag_high_port1 <= `DIS_LAG_HIGH_RESET;
        end
        else
        begin
            split_buffer_lag_low        <= next_lag_low0;
            split_buffer_lag_low_port1  <= next_lag_low1;
            split_buffer_lag_high       <= next_lag_high0;
            split_buffer_lag_high_port1 <= next_lag_high1;
        end
    end

    // reserved and unmapped reads return zero
    always_comb
    begin
        next_rdata = `DIS_RDATA_IDLE;
        if (i_req.rd)
        begin
            case (i_req.addr)
                `DIS_OFF_LINE_LOW:  next_rdata = split_line_width_low;
                `DIS_OFF_LINE_HIGH: next_rdata = {3'h0, split_line_width_high};
                `DIS_OFF_LAG_LOW:   next_rdata = seen_lag_low;
                `DIS_OFF_LAG_HIGH:  next_rdata = {3'h0, seen_lag_high};
                `DIS_OFF_PORT_SEL:  next_rdata = {7'h00, port_sel};
                default:            next_rdata = `DIS_RDATA_IDLE;
            endcase
        end
    end

    // Read data stands one cycle, then drops to zero
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            rdata <= `DIS_RDATA_IDLE;
        else
            rdata <= next_rdata;
    end

    assign o_rdata    = rdata;
    assign o_port_sel = port_sel;
    // one width serves 2D and dual-input
    assign o_line_width = join_pix(split_line_width_high, split_line_width_low);
    // combined 3D line twice the 2D width
    // One extra bit so the 4096 limit doubles without wrapping
    assign o_combined_width = {o_line_width, 1'b0};
    // lag in pixels feeds splitter buffer
    assign o_lag_port0 = join_pix(split_buffer_lag_high, split_buffer_lag_low);
    assign o_lag_port1 = join_pix(split_buffer_lag_high_port1, split_buffer_lag_low_port1);
    // flag width above the supported limit
    assign o_line_over_limit = o_line_width > LIMIT_PIXELS;
    // flag lag above the limit; values kept, not clamped
    assign o_lag_over_limit = (o_lag_port0 > LIMIT_PIXELS)
                            || (o_lag_port1 > LIMIT_PIXELS);

endmodule // dis_split_config

// file: testbench/dis_split_config_props.sv
// Checker for the split configuration bank
`timescale 1ns/10ps
module dis_split_config_props
    import dis_pkg::*;
(
    // Clock, reset and request
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire dis_req_s   i_req,
    // Observed outputs
    input  wire logic [7:0] o_rdata,
    input  wire dis_pix_t   o_line_width,
    input  wire logic [13:0] o_combined_width,
    input  wire dis_pix_t   o_lag_port0,
    input  wire dis_pix_t   o_lag_port1,
    input  wire logic       o_port_sel,
    input  wire logic       o_line_over_limit,
    input  wire logic       o_lag_over_limit
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    property p_lo; i_req.wr && i_req.addr == 8'h32 |=> o_line_width[7:0] == $past(i_req.wdata);
    endproperty
    a_lo: assert property (p_lo) else $error("line low byte");
    property p_hi; i_req.wr && i_req.addr == 8'h33
        |=> o_line_width[12:8] == $past(i_req.wdata[4:0]); endproperty
    a_hi: assert property (p_hi) else $error("line high field");
    property p_dbl; o_combined_width == {o_line_width, 1'h0}; endproperty
    a_dbl: assert property (p_dbl) else $error("combined width");
    property p_flag; o_line_over_limit == (o_line_width > 13'h1000); endproperty
    a_flag: assert property (p_flag) else $error("line limit flag");
    property p_rsv; i_req.rd && i_req.addr == 8'h33 |=> o_rdata[7:5] == 3'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits");
    property p_unm; i_req.rd && i_req.addr == 8'h40 |=> o_rdata == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_l0; i_req.wr && i_req.addr == 8'h34 && !o_port_sel
        |=> o_lag_port0[7:0] == $past(i_req.wdata) && $stable(o_lag_port1); endproperty
    a_l0: assert property (p_l0) else $error("port0 lag");
    property p_l1; i_req.wr && i_req.addr == 8'h34 && o_port_sel
        |=> o_lag_port1[7:0] == $past(i_req.wdata) && $stable(o_lag_port0); endproperty
    a_l1: assert property (p_l1) else $error("port1 lag");
    property p_sel; i_req.wr && i_req.addr == 8'h3f |=> o_port_sel == $past(i_req.wdata[0]);
    endproperty
    a_sel: assert property (p_sel) else $error("port select");
    property p_lh0; i_req.wr && i_req.addr == 8'h35 && !o_port_sel
        |=> o_lag_port0[12:8] == $past(i_req.wdata[4:0]) && $stable(o_lag_port1); endproperty
    a_lh0: assert property (p_lh0) else $error("port0 lag high");
    property p_gflag; o_lag_over_limit == (o_lag_port0 > 13'h1000 || o_lag_port1 > 13'h1000);
    endproperty
    a_gflag: assert property (p_gflag) else $error("lag limit flag");
endmodule // dis_split_config_props
bind dis_split_config dis_split_config_props dis_split_config_props_inst (.*);

// file: testbench/tb_dis_split_config.sv
// Self-checking bench for the split configuration bank
`timescale 1ns/10ps
module tb_dis_split_config;
    import dis_pkg::*;
    logic       i_core_clk = 1'h0;
    logic       i_rst = 1'h1;
    dis_req_s   i_req = '0;
    logic [7:0] o_rdata;
    dis_pix_t   lw, lag0, lag1;
    logic [13:0] cw;
    logic       sel, lover, gover;
    int         n_errors = 0;
    int         n_tests = 0;
    always #5 i_core_clk = ~i_core_clk;
    dis_split_config dis_split_config_inst (.i_core_clk, .i_rst, .i_req, .o_rdata,
        .o_line_width(lw), .o_combined_width(cw), .o_lag_port0(lag0), .o_lag_port1(lag1),
        .o_port_sel(sel), .o_line_over_limit(lover), .o_lag_over_limit(gover));
    task automatic chk(input logic [13:0] s, input logic [13:0] e);
        n_tests++;
        if (s !== e)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    // One bus cycle; results settle just after the taking edge
    task automatic op(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge i_core_clk);
        i_req <= '{a, d, w, !w};
        @(posedge i_core_clk);
        i_req <= '0;
        #1;
    endtask
    task automatic test_done;
        if (n_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_reset;
        #1;
        chk(lw, 13'h0500);
        chk(lag0, 13'h000c);
        chk(lag1, 13'h000c);
        chk(sel, 1'h0);
        chk(lover, 1'h0);
        chk(gover, 1'h0);
        op(8'h33, 8'h00, 1'h0);
        chk(o_rdata, 8'h05);
        @(posedge i_core_clk);
        #1;
        chk(o_rdata, 8'h00);
    endtask
    task automatic t_width;
        op(8'h32, 8'hff, 1'h1);
        op(8'h33, 8'hff, 1'h1);
        chk(lw, 13'h1fff);
        chk(cw, 14'h3ffe);
        chk(lover, 1'h1);
        op(8'h32, 8'h00, 1'h0);
        chk(o_rdata, 8'hff);
        op(8'h33, 8'h00, 1'h0);
        chk(o_rdata, 8'h1f);
        op(8'h33, 8'h10, 1'h1);
        op(8'h32, 8'h00, 1'h1);
        chk(lover, 1'h0);
        chk(lw, 13'h1000);
        chk(cw, 14'h2000);
    endtask
    task automatic t_lag;
        op(8'h3f, 8'h01, 1'h1);
        chk(sel, 1'h1);
        op(8'h34, 8'h20, 1'h1);
        op(8'h35, 8'he1, 1'h1);
        chk(lag1, 13'h0120);
        chk(lag0, 13'h000c);
        op(8'h34, 8'h00, 1'h0);
        chk(o_rdata, 8'h20);
        op(8'h35, 8'h00, 1'h0);
        chk(o_rdata, 8'h01);
        op(8'h3f, 8'h00, 1'h1);
        op(8'h34, 8'h0d, 1'h1);
        chk(lag0, 13'h000d);
        chk(lag1, 13'h0120);
        op(8'h40, 8'h00, 1'h0);
        chk(o_rdata, 8'h00);
        op(8'h34, 8'h20 + 8'h58, 1'h1);
        chk(lag0, 13'h0078);
        op(8'h35, 8'h10, 1'h1);
        op(8'h34, 8'h01, 1'h1);
        chk(gover, 1'h1);
        op(8'h35, 8'h00, 1'h1);
        chk(gover, 1'h0);
    endtask
    // Reset in mid-run must restore every register
    task automatic t_rerun;
        op(8'h3f, 8'h01, 1'h1);
        @(posedge i_core_clk);
        i_rst <= 1'h1;
        #1;
        chk(lw, 13'h0500);
        chk(lag0, 13'h000c);
        chk(lag1, 13'h000c);
        chk(sel, 1'h0);
        @(posedge i_core_clk);
        i_rst <= 1'h0;
        op(8'h34, 8'h00, 1'h0);
        chk(o_rdata, 8'h0c);
    endtask
    initial
    begin
        repeat (3) @(posedge i_core_clk);
        i_rst <= 1'h0;
        t_reset;
        t_width;
        t_lag;
        t_rerun;
        test_done;
    end
    // Watchdog against a hung run
    initial
    begin
        #100000;
        n_errors++;
        test_done;
    end
endmodule // tb_dis_split_config
